// [hw/host_misc_system_registers.sv]
// Host-visible system registers: timer view, halfword order, counters, MAC access.
//
// Function
// - Timer count register shows live 16-bit timer value, all ones after reset.
// - Timer enable falling edge reloads the timer preload with all ones.
// - Transmit data leaves the FIFO low-order halfword first.
// - Received data enters the FIFO with low-order halfword first.
// - Halfword order select matters only on a sixteen-bit host bus.
// - Thirty-two-bit bus: upper lines high halfword, lower lines low halfword.
// - Sixteen-bit, select not all ones: address bit one high reaches high half.
// - Sixteen-bit, select all ones: address bit one high reaches low half.
// - Free-running 32-bit counter starts at zero, counts every 25 MHz cycle.
// - Free-running counter wraps from maximum to zero and keeps counting.
// - Sixteen-bit reads of free-running counter latch whole count on first read.
// - Free-running counter may take up to 160 ns to read cleared after reset.
// - Free-running counter keeps counting in every power management state.
// - Each discarded received frame adds one to the dropped-frame tally.
// - Any read of the dropped-frame tally returns it and clears it.
// - Tally stepping from just below halfway to halfway raises an event.
// - Writing pending bit one starts MAC access; bit stays set until done.
// - Indirect read clears pending only once read data sits in data register.
// - Direction bit set means MAC read, clear means MAC write.
// - Low command byte selects the target MAC register.
// - Indirect data register holds write value and receives read value.
`timescale 1ns/1ps
`default_nettype none
`include "hmsr_defs.svh"

module host_misc_system_registers
  import hmsr_pkg::*;
#(
  parameter int TICK_DIV = `SYS_CLK_MHZ / `TICK_CLK_MHZ
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_cs_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_wr_n,
  input  wire logic [7:1]  i_addr,
  input  wire logic [31:0] i_data,
  output logic      [31:0] o_data,
  output logic             o_data_oe_n,
  input  wire logic        i_bus16,
  input  wire logic [15:0] i_timer_count,
  input  wire logic        i_timer_en,
  output logic             o_preload_to_ones,
  input  wire logic        i_rx_frame_dropped,
  output logic             o_drop_halfway,
  output logic             o_mac_req,
  output logic             o_mac_read,
  output logic      [7:0]  o_mac_addr,
  output logic      [31:0] o_mac_wdata,
  input  wire logic        i_mac_ack,
  input  wire logic [31:0] i_mac_rdata
);

  localparam int PIN_W = 43;
  localparam logic [`TICK_DIV_W-1:0] TICK_LAST = `TICK_DIV_W'(TICK_DIV - 1);

  // ========================================================================
  // Host pin synchroniser
  // ========================================================================
  logic [PIN_W-1:0] pin_meta_q;
  logic [PIN_W-1:0] pin_sync_q;
  logic             bus16;
  logic             cs_n_s;
  logic             rd_n_s;
  logic             wr_n_s;
  logic [7:1]       addr_s;
  logic [31:0]      data_s;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_meta_q <= '1;
      pin_sync_q <= '1;
    end else begin
      pin_meta_q <= {i_bus16, i_cs_n, i_rd_n, i_wr_n, i_addr, i_data};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign {bus16, cs_n_s, rd_n_s, wr_n_s, addr_s, data_s} = pin_sync_q;

  // ========================================================================
  // Strobe edges and halfword steering
  // ========================================================================
  logic  rd_act;
  logic  wr_act;
  logic  rd_prev_q;
  logic  wr_prev_q;
  logic  rd_start;
  logic  wr_start;
  logic  swap_halves;
  logic  hi_sel;
  logic [7:0] word_addr;
  word_t wdat;
  word_t wmask;
  word_t order_q, order_d;

  assign rd_act   = !cs_n_s && !rd_n_s;
  assign wr_act   = !cs_n_s && !wr_n_s;
  assign rd_start = rd_act && !rd_prev_q;
  assign wr_start = wr_act && !wr_prev_q;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_prev_q <= 1'b0;
      wr_prev_q <= 1'b0;
    end else begin
      rd_prev_q <= rd_act;
      wr_prev_q <= wr_act;
    end
  end

  assign word_addr = {addr_s[7:2], 2'b00};

  // Only the sixteen-bit bus looks at the order select.
  assign swap_halves = (order_q == `ORDER_SWAP_ALL);
  assign hi_sel      = addr_s[1] ^ swap_halves;

  // Write lanes: full word on a wide bus, one steered halfword otherwise.
  always_comb begin
    if (bus16) begin
      wdat  = {data_s[15:0], data_s[15:0]};
      wmask = hi_sel ? `MASK_HI_HALF : `MASK_LO_HALF;
    end else begin
      wdat  = data_s;
      wmask = `MASK_ALL;
    end
  end

  function automatic word_t merge(input word_t old_v, input word_t new_v,
                                  input word_t mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction

  function automatic word_t lane_out(input word_t v, input logic narrow,
                                     input logic hi);
    if (!narrow) begin
      lane_out = v;
    end else if (hi) begin
      lane_out = {`HALF_ZERO, v[31:16]};
    end else begin
      lane_out = {`HALF_ZERO, v[15:0]};
    end
  endfunction

  // ========================================================================
  // Timer view, preload reload and free-running counter
  // ========================================================================
  logic [15:0]           timer_q;
  logic                  timer_en_q;
  logic                  preload_q;
  logic [`TICK_DIV_W-1:0] div_q, div_d;
  word_t                 free_running_tick_count_q, free_running_tick_count_d;

  always_comb begin
    div_d    = div_q + `TICK_DIV_W'(1);
    free_running_tick_count_d = free_running_tick_count_q;
    if (div_q == TICK_LAST) begin
      div_d    = '0;
      free_running_tick_count_d = free_running_tick_count_q + `WORD_ONE;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      timer_q    <= `TIMER_COUNT_RST;
      timer_en_q <= 1'b0;
      preload_q  <= 1'b0;
      div_q      <= '0;
      free_running_tick_count_q   <= `WORD_ZERO;
    end else begin
      timer_q    <= i_timer_count;
      timer_en_q <= i_timer_en;
      preload_q  <= timer_en_q && !i_timer_en;
      div_q      <= div_d;
      free_running_tick_count_q   <= free_running_tick_count_d;
    end
  end

  assign o_preload_to_ones = preload_q;

  // ========================================================================
  // Register bank
  // ========================================================================
  mac_csr_if csr ();

  word_t drop_q, drop_d;
  word_t cmd_q, cmd_d;
  word_t data_q, data_d;
  word_t snap_q, snap_d;
  logic  fr_half_q, fr_half_d;
  logic  start_q, start_d;
  logic  half_ev_q, half_ev_d;
  word_t rdata_q, rdata_d;
  word_t cmd_new;
  word_t fr_view;
  logic  pending;

  assign pending = cmd_q[`CMD_PEND_BIT];

  always_comb begin
    order_d   = order_q;
    drop_d    = drop_q;
    cmd_d     = cmd_q;
    data_d    = data_q;
    snap_d    = snap_q;
    fr_half_d = fr_half_q;
    start_d   = 1'b0;
    half_ev_d = 1'b0;
    rdata_d   = rdata_q;
    cmd_new   = merge(cmd_q, wdat, wmask) & `CMD_WR_MASK;
    fr_view   = free_running_tick_count_q;

    // Dropped frames; a read clears but never loses a coinciding drop.
    if (rd_start && word_addr == `OFF_DROP_TALLY) begin
      drop_d = i_rx_frame_dropped ? `WORD_ONE : `WORD_ZERO;
    end else if (i_rx_frame_dropped) begin
      drop_d    = drop_q + `WORD_ONE;
      half_ev_d = (drop_q == `DROP_HALF_BELOW);
    end

    // Host writes; command and data are held while an access is pending.
    if (wr_start) begin
      if (word_addr == `OFF_ORDER_SELECT) begin
        order_d = merge(order_q, wdat, wmask);
      end else if (word_addr == `OFF_MAC_CMD && !pending) begin
        cmd_d   = cmd_new;
        start_d = cmd_new[`CMD_PEND_BIT];
      end else if (word_addr == `OFF_MAC_DATA && !pending) begin
        data_d = merge(data_q, wdat, wmask);
      end
    end

    // Finished access; read data lands in the same cycle that pending drops.
    if (csr.done) begin
      cmd_d[`CMD_PEND_BIT] = 1'b0;
      if (cmd_q[`CMD_DIR_BIT]) begin
        data_d = csr.rdata;
      end
    end

    // Sixteen-bit free-run reads: the first half freezes the whole count.
    if (bus16 && fr_half_q) begin
      fr_view = snap_q;
    end

    if (rd_start) begin
      if (word_addr == `OFF_TIMER_COUNT) begin
        rdata_d = lane_out({`HALF_ZERO, timer_q}, bus16, hi_sel);
      end else if (word_addr == `OFF_ORDER_SELECT) begin
        rdata_d = lane_out(order_q, bus16, hi_sel);
      end else if (word_addr == `OFF_FREE_RUN) begin
        rdata_d = lane_out(fr_view, bus16, hi_sel);
        if (bus16) begin
          snap_d    = free_running_tick_count_q;
          fr_half_d = !fr_half_q;
        end
      end else if (word_addr == `OFF_DROP_TALLY) begin
        rdata_d = lane_out(drop_q, bus16, hi_sel);
      end else if (word_addr == `OFF_MAC_CMD) begin
        rdata_d = lane_out(cmd_q, bus16, hi_sel);
      end else if (word_addr == `OFF_MAC_DATA) begin
        rdata_d = lane_out(data_q, bus16, hi_sel);
      end else begin
        rdata_d = `WORD_ZERO;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      order_q   <= `ORDER_RST;
      drop_q    <= `DROP_RST;
      cmd_q     <= `CMD_RST;
      data_q    <= `DATA_RST;
      snap_q    <= `WORD_ZERO;
      fr_half_q <= 1'b0;
      start_q   <= 1'b0;
      half_ev_q <= 1'b0;
      rdata_q   <= `WORD_ZERO;
    end else begin
      order_q   <= order_d;
      drop_q    <= drop_d;
      cmd_q     <= cmd_d;
      data_q    <= data_d;
      snap_q    <= snap_d;
      fr_half_q <= fr_half_d;
      start_q   <= start_d;
      half_ev_q <= half_ev_d;
      rdata_q   <= rdata_d;
    end
  end

  assign o_drop_halfway = half_ev_q;
  assign o_data         = rdata_q;
  assign o_data_oe_n    = !(rd_act && rd_prev_q);

  // ========================================================================
  // MAC register access
  // ========================================================================
  assign csr.start = start_q;
  assign csr.read  = cmd_q[`CMD_DIR_BIT];
  assign csr.addr  = cmd_q[`CMD_ADDR_MSB:0];
  assign csr.wdata = data_q;

  mac_csr_seq u_mac_csr_seq (
    .i_sys_clk   (i_sys_clk),
    .i_arst_n    (i_arst_n),
    .csr         (csr.seq),
    .o_mac_req   (o_mac_req),
    .o_mac_read  (o_mac_read),
    .o_mac_addr  (o_mac_addr),
    .o_mac_wdata (o_mac_wdata),
    .i_mac_ack   (i_mac_ack),
    .i_mac_rdata (i_mac_rdata)
  );

endmodule

`default_nettype wire

// [hw/mac_csr_seq.sv]
// Sequencer that carries one indirect access to the MAC register port.
`timescale 1ns/1ps
`default_nettype none
`include "hmsr_defs.svh"

module mac_csr_seq
  import hmsr_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_arst_n,
  mac_csr_if.seq          csr,
  output logic            o_mac_req,
  output logic            o_mac_read,
  output logic [7:0]      o_mac_addr,
  output logic [31:0]     o_mac_wdata,
  input  wire logic       i_mac_ack,
  input  wire logic [31:0] i_mac_rdata
);

  mac_seq_state_t state_q, state_d;
  logic           read_q, read_d;
  logic [7:0]     addr_q, addr_d;
  logic [31:0]    wdata_q, wdata_d;
  logic [31:0]    rdata_q, rdata_d;

  // ========================================================================
  // Access sequence
  // ========================================================================
  always_comb begin
    state_d = state_q;
    read_d  = read_q;
    addr_d  = addr_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    case (state_q)
      MAC_IDLE: begin
        if (csr.start) begin
          read_d  = csr.read;
          addr_d  = csr.addr;
          wdata_d = csr.wdata;
          state_d = MAC_BUSY;
        end
      end
      MAC_BUSY: begin
        if (i_mac_ack) begin
          if (read_q) begin
            rdata_d = i_mac_rdata;
          end
          state_d = MAC_DONE;
        end
      end
      MAC_DONE: begin
        state_d = MAC_IDLE;
      end
      default: begin
        state_d = MAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= MAC_IDLE;
      read_q  <= 1'b0;
      addr_q  <= 8'h00;
      wdata_q <= `WORD_ZERO;
      rdata_q <= `WORD_ZERO;
    end else begin
      state_q <= state_d;
      read_q  <= read_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_mac_req   = (state_q == MAC_BUSY);
  assign o_mac_read  = read_q;
  assign o_mac_addr  = addr_q;
  assign o_mac_wdata = wdata_q;
  assign csr.done    = (state_q == MAC_DONE);
  assign csr.rdata   = rdata_q;

endmodule

`default_nettype wire

// [include/hmsr_defs.svh]
// Register offsets, field positions, reset values and timing constants.
`ifndef HMSR_DEFS_SVH
`define HMSR_DEFS_SVH

// ==========================================================================
// Register word offsets
// ==========================================================================
`define OFF_TIMER_COUNT   8'h90
`define OFF_ORDER_SELECT  8'h98
`define OFF_FREE_RUN      8'h9C
`define OFF_DROP_TALLY    8'hA0
`define OFF_MAC_CMD       8'hA4
`define OFF_MAC_DATA      8'hA8

// ==========================================================================
// Fields and reset values
// ==========================================================================
`define TIMER_COUNT_RST   16'hFFFF
`define ORDER_RST         32'h0000_0000
`define ORDER_SWAP_ALL    32'hFFFF_FFFF
`define DROP_RST          32'h0000_0000
`define DROP_HALF_BELOW   32'h7FFF_FFFF
`define DATA_RST          32'h0000_0000
`define CMD_RST           32'h0000_0000
`define CMD_PEND_BIT      31
`define CMD_DIR_BIT       30
`define CMD_ADDR_MSB      7
`define CMD_WR_MASK       32'hC000_00FF
`define MASK_ALL          32'hFFFF_FFFF
`define MASK_HI_HALF      32'hFFFF_0000
`define MASK_LO_HALF      32'h0000_FFFF
`define HALF_ZERO         16'h0000
`define WORD_ZERO         32'h0000_0000
`define WORD_ONE          32'h0000_0001

// ==========================================================================
// Timing
// ==========================================================================
`define SYS_CLK_MHZ       100
`define TICK_CLK_MHZ      25
`define TICK_DIV_W        4

`endif

// [include/hmsr_pkg.sv]
// Types shared by the system register bank and its MAC access sequencer.
package hmsr_pkg;

  typedef enum logic [1:0] {
    MAC_IDLE,
    MAC_BUSY,
    MAC_DONE
  } mac_seq_state_t;

  typedef logic [31:0] word_t;

endpackage

// [include/mac_csr_if.sv]
// Request and answer signals between the register bank and the MAC sequencer.
`timescale 1ns/1ps
`default_nettype none

interface mac_csr_if;
  logic        start;
  logic        read;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic        done;
  logic [31:0] rdata;

  modport bank (output start, output read, output addr, output wdata,
                input done, input rdata);
  modport seq  (input start, input read, input addr, input wdata,
                output done, output rdata);
endinterface

`default_nettype wire

// [tb/hmsr_monitor.sv]
// Port-level checker for the host system register bank.
`timescale 1ns/1ps
`default_nettype none

module hmsr_monitor (
  input wire logic        i_sys_clk,
  input wire logic        i_arst_n,
  input wire logic        i_cs_n,
  input wire logic        i_rd_n,
  input wire logic        i_timer_en,
  input wire logic        i_rx_frame_dropped,
  input wire logic        i_mac_ack,
  input wire logic [31:0] o_data,
  input wire logic        o_data_oe_n,
  input wire logic        o_preload_to_ones,
  input wire logic        o_drop_halfway,
  input wire logic        o_mac_req,
  input wire logic        o_mac_read,
  input wire logic [7:0]  o_mac_addr,
  input wire logic [31:0] o_mac_wdata
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);

  property p_preload_pulse;
    $fell(i_timer_en) |-> ##[1:2] o_preload_to_ones;
  endproperty
  a_preload_pulse: assert property (p_preload_pulse) else $error("preload pulse missing");
  property p_preload_once;
    o_preload_to_ones |=> !o_preload_to_ones;
  endproperty
  a_preload_once: assert property (p_preload_once) else $error("preload pulse too long");
  property p_preload_cause;
    o_preload_to_ones |-> $past(i_timer_en, 2) || $past(i_timer_en, 3);
  endproperty
  a_preload_cause: assert property (p_preload_cause) else $error("preload without cause");
  property p_half_once;
    o_drop_halfway |=> !o_drop_halfway;
  endproperty
  a_half_once: assert property (p_half_once) else $error("halfway pulse too long");
  property p_half_cause;
    o_drop_halfway |-> $past(i_rx_frame_dropped) || $past(i_rx_frame_dropped, 2);
  endproperty
  a_half_cause: assert property (p_half_cause) else $error("halfway without drop");
  property p_req_hold;
    o_mac_req && !i_mac_ack && !$past(i_mac_ack) |=> o_mac_req && $stable(o_mac_addr)
      && $stable(o_mac_read) && $stable(o_mac_wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("mac request changed early");
  property p_req_end;
    i_mac_ack |-> ##2 !o_mac_req;
  endproperty
  a_req_end: assert property (p_req_end) else $error("mac request not released");
  property p_oe_idle;
    i_rd_n [*3] |-> o_data_oe_n;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("data bus driven without read");
  property p_oe_read;
    (!i_cs_n && !i_rd_n) [*5] |-> !o_data_oe_n;
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("data bus not driven in read");
  property p_data_hold;
    i_rd_n [*5] |-> $stable(o_data);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("read data changed idle");

  c_mac_done: cover property (o_mac_req && i_mac_ack);
  c_read: cover property (!o_data_oe_n);
  c_preload: cover property (o_preload_to_ones);
endmodule

bind host_misc_system_registers hmsr_monitor u_mon (
  .i_sys_clk, .i_arst_n, .i_cs_n, .i_rd_n, .i_timer_en, .i_rx_frame_dropped, .i_mac_ack,
  .o_data, .o_data_oe_n, .o_preload_to_ones, .o_drop_halfway, .o_mac_req, .o_mac_read,
  .o_mac_addr, .o_mac_wdata
);

`default_nettype wire

// [tb/host_misc_system_registers_tb.sv]
// Self-checking bench for the host system register bank.
`timescale 1ns/1ps
`default_nettype none
`include "hmsr_defs.svh"

module host_misc_system_registers_tb;
  import hmsr_pkg::*;
  logic        clk, rst_n, cs_n, rd_n, wr_n, bus16, ten, drop, oe_n, pre, half;
  logic        mreq, mrd, ack;
  logic [7:1]  addr;
  logic [7:0]  maddr, a;
  logic [15:0] tcnt;
  logic [3:0]  lat;
  word_t       wdata, rdata, mwd, mrdat, v, w, x, o, shadow [256];
  int          fails, cmp_count, seed, n;

  host_misc_system_registers DUT (
    .i_sys_clk(clk), .i_arst_n(rst_n), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_addr(addr), .i_data(wdata), .o_data(rdata), .o_data_oe_n(oe_n), .i_bus16(bus16),
    .i_timer_count(tcnt), .i_timer_en(ten), .o_preload_to_ones(pre),
    .i_rx_frame_dropped(drop), .o_drop_halfway(half), .o_mac_req(mreq), .o_mac_read(mrd),
    .o_mac_addr(maddr), .o_mac_wdata(mwd), .i_mac_ack(ack), .i_mac_rdata(mrdat));
  mac_reg_model u_mac (
    .i_sys_clk(clk), .i_arst_n(rst_n), .i_req(mreq), .i_read(mrd), .i_addr(maddr),
    .i_wdata(mwd), .i_lat(lat), .o_ack(ack), .o_rdata(mrdat));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input word_t got, input word_t exp);
    cmp_count++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  // One host access of eight cycles; strobes held five, gap of three.
  task automatic acc(input logic rd, input logic [7:0] off, input word_t d, output word_t q);
    addr = off[7:1];
    wdata = d;
    cs_n = 1'b0;
    rd_n = !rd;
    wr_n = rd;
    repeat (5) @(negedge clk);
    q = rdata;
    {cs_n, rd_n, wr_n} = 3'b111;
    repeat (3) @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] off, input word_t exp);
    acc(1'b1, off, `WORD_ZERO, v);
    chk(v, exp);
  endtask

  task automatic wr(input logic [7:0] off, input word_t d);
    acc(1'b0, off, d, w);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wait_idle;
    n = 0;
    acc(1'b1, `OFF_MAC_CMD, `WORD_ZERO, v);
    while (v[`CMD_PEND_BIT] !== 1'b0) begin
      n++;
      if (n > 20) begin
        fails++;
        report_and_stop;
      end
      acc(1'b1, `OFF_MAC_CMD, `WORD_ZERO, v);
    end
  endtask

  task automatic pulse_drop;
    drop = 1'b1;
    @(negedge clk);
    drop = 1'b0;
  endtask

  function automatic word_t half_of(input word_t d, input logic a1, input word_t sel);
    return (a1 ^ (sel === `ORDER_SWAP_ALL)) ? {`HALF_ZERO, d[31:16]} : {`HALF_ZERO, d[15:0]};
  endfunction

  initial begin
    {cs_n, rd_n, wr_n} = 3'b111;
    {rst_n, bus16, ten, drop} = 4'h0;
    addr = 7'h00;
    wdata = `WORD_ZERO;
    tcnt = 16'hFFFF;
    lat = 4'h0;
    seed = 97;
    for (int i = 0; i < 256; i++) shadow[i] = {4{i[7:0]}} ^ 32'h5A5A_A5A5;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    rd(`OFF_TIMER_COUNT, {`HALF_ZERO, `TIMER_COUNT_RST});
    rd(`OFF_ORDER_SELECT, `ORDER_RST);
    rd(`OFF_DROP_TALLY, `DROP_RST);
    rd(`OFF_MAC_CMD, `CMD_RST);
    wr(`OFF_TIMER_COUNT, 32'h1234_5678);
    wr(8'h94, 32'h1234_5678);
    rd(8'h94, `WORD_ZERO);
    for (int i = 0; i < 4; i++) begin
      tcnt = 16'($random(seed));
      rd(`OFF_TIMER_COUNT, {`HALF_ZERO, tcnt});
    end
    ten = 1'b1;
    repeat (3) @(negedge clk);
    ten = 1'b0;
    v = `WORD_ZERO;
    repeat (4) begin
      @(negedge clk);
      v[0] = v[0] | pre;
    end
    chk(v, `WORD_ONE);
    $display("test timer_view done");
    acc(1'b1, `OFF_FREE_RUN, `WORD_ZERO, w);
    acc(1'b1, `OFF_FREE_RUN, `WORD_ZERO, x);
    chk(x - w, 32'h0000_0002);
    $display("test free_run done");
    foreach (shadow[i]) if (i < 3) begin
      o = (i == 0) ? `ORDER_RST : ((i == 1) ? 32'hFFFF_FFFE : `ORDER_SWAP_ALL);
      x = $random(seed);
      bus16 = 1'b0;
      wr(`OFF_ORDER_SELECT, o);
      wr(`OFF_MAC_DATA, x);
      rd(`OFF_MAC_DATA, x);
      bus16 = 1'b1;
      repeat (3) @(negedge clk);
      rd(`OFF_MAC_DATA, half_of(x, 1'b0, o));
      rd(`OFF_MAC_DATA | 8'h02, half_of(x, 1'b1, o));
    end
    acc(1'b1, `OFF_FREE_RUN, `WORD_ZERO, v);
    acc(1'b1, `OFF_FREE_RUN | 8'h02, `WORD_ZERO, w);
    x = {v[15:0], w[15:0]};
    acc(1'b1, `OFF_FREE_RUN, `WORD_ZERO, v);
    acc(1'b1, `OFF_FREE_RUN | 8'h02, `WORD_ZERO, w);
    chk({v[15:0], w[15:0]} - x, 32'h0000_0004);
    acc(1'b1, `OFF_FREE_RUN | 8'h02, `WORD_ZERO, v);
    acc(1'b1, `OFF_FREE_RUN | 8'h02, `WORD_ZERO, w);
    chk(w, v);
    bus16 = 1'b0;
    repeat (3) @(negedge clk);
    $display("test halfword_order done");
    n = 1 + ($unsigned($random(seed)) % 20);
    repeat (n) begin
      pulse_drop;
      @(negedge clk);
    end
    rd(`OFF_DROP_TALLY, n);
    rd(`OFF_DROP_TALLY, `WORD_ZERO);
    for (int k = 0; k < 8; k++) begin
      fork
        acc(1'b1, `OFF_DROP_TALLY, `WORD_ZERO, w);
        begin
          repeat (k) @(negedge clk);
          pulse_drop;
        end
      join
      acc(1'b1, `OFF_DROP_TALLY, `WORD_ZERO, x);
      chk(w + x, `WORD_ONE);
    end
    $display("test drop_tally done");
    for (int i = 0; i < 6; i++) begin
      a = 8'($random(seed));
      x = $random(seed);
      lat = i[0] ? 4'hF : 4'h0;
      wr(`OFF_MAC_CMD, {2'b11, 22'h0, a});
      wait_idle;
      rd(`OFF_MAC_DATA, shadow[a]);
      wr(`OFF_MAC_DATA, x);
      wr(`OFF_MAC_CMD, {2'b10, 22'h0, a});
      if (i[0]) wr(`OFF_MAC_DATA, ~x);
      wait_idle;
      chk(v, {2'b00, 22'h0, a});
      rd(`OFF_MAC_DATA, x);
      shadow[a] = x;
      wr(`OFF_MAC_CMD, {2'b11, 22'h0, a});
      wait_idle;
      rd(`OFF_MAC_DATA, x);
    end
    $display("test mac_indirect done");
    report_and_stop;
  end
endmodule

`default_nettype wire

// [tb/mac_reg_model.sv]
// Behavioural MAC register file answering indirect accesses.
`timescale 1ns/1ps
`default_nettype none

module mac_reg_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_arst_n,
  input  wire logic        i_req,
  input  wire logic        i_read,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_lat,
  output logic             o_ack,
  output logic      [31:0] o_rdata
);
  logic [31:0] mem [256];
  logic [31:0] rd_q;
  logic [3:0]  cnt;
  logic        seen;

  initial for (int i = 0; i < 256; i++) mem[i] = {4{i[7:0]}} ^ 32'h5A5A_A5A5;
  // Read data is only valid with the acknowledge; it shows the inverse otherwise.
  assign o_rdata = o_ack ? rd_q : ~rd_q;

  always @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ack <= 1'b0;
      cnt   <= 4'h0;
      seen  <= 1'b0;
      rd_q  <= 32'h0000_0000;
    end else begin
      o_ack <= 1'b0;
      if (!i_req) begin
        seen <= 1'b0;
      end else if (!seen && cnt >= i_lat) begin
        o_ack <= 1'b1;
        seen  <= 1'b1;
        cnt   <= 4'h0;
        rd_q  <= mem[i_addr];
        if (!i_read) mem[i_addr] <= i_wdata;
      end else if (!seen) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

`default_nettype wire
